//--- rtl/bbnc_top.sv
`timescale 1ns/10ps
`default_nettype none
module bbnc_top (
   input  wire logic        sys_clk_i,
   input  wire logic        resetn_i,
   input  wire logic        cfg_req_i,
   input  wire logic        cfg_wr_i,
   input  wire logic [7:0]  cfg_addr_i,
   input  wire logic [3:0]  cfg_be_n_i,
   input  wire logic [31:0] cfg_wdata_i,
   output logic [31:0]      cfg_rdata_o,
   output logic             cfg_ack_o,
   input  wire logic        t1_req_i,
   input  wire logic        t1_from_up_i,
   input  wire logic [7:0]  t1_bus_i,
   input  wire logic        t1_special_i,
   output logic             t1_valid_o,
   output logic [3:0]       t1_route_o,
   output logic [7:0]       up_bus_o,
   output logic [7:0]       dn_bus_o,
   output logic [7:0]       hi_bus_o
);
   logic [7:0]            up_bus_reg;
   logic [7:0]            dn_bus_reg;
   logic [7:0]            hi_bus_reg;
   bbnc_pkg::bbnc_route_t route_next;
   logic                  wr_bus;

   // Byte enables are active low, as on the PCI command/byte-enable lines
   assign wr_bus = cfg_req_i && cfg_wr_i && (cfg_addr_i == bbnc_pkg::BBNC_OFS_BUSNUM);

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         up_bus_reg <= bbnc_pkg::BBNC_BUS_RST;
         dn_bus_reg <= bbnc_pkg::BBNC_BUS_RST;
         hi_bus_reg <= bbnc_pkg::BBNC_BUS_RST;
      end else if (wr_bus) begin
         if (!cfg_be_n_i[0]) begin
            up_bus_reg <= cfg_wdata_i[bbnc_pkg::BBNC_UP_LSB +: 8];
         end
         if (!cfg_be_n_i[1]) begin
            dn_bus_reg <= cfg_wdata_i[bbnc_pkg::BBNC_DN_LSB +: 8];
         end
         if (!cfg_be_n_i[2]) begin
            hi_bus_reg <= cfg_wdata_i[bbnc_pkg::BBNC_HI_LSB +: 8];
         end
      end
   end

   // Header dword: writes ignored, reserved byte zero; unmapped offsets read zero
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_rdata_o <= 32'h0000_0000;
         cfg_ack_o   <= 1'b0;
      end else begin
         cfg_ack_o   <= cfg_req_i;
         cfg_rdata_o <= 32'h0000_0000;
         if (cfg_req_i && !cfg_wr_i) begin
            case (cfg_addr_i)
               bbnc_pkg::BBNC_OFS_HDR: begin
                  cfg_rdata_o <= {8'h00, bbnc_pkg::BBNC_HDR_TYPE_VAL, 16'h0000};
               end
               bbnc_pkg::BBNC_OFS_BUSNUM: begin
                  cfg_rdata_o <= {8'h00, hi_bus_reg, dn_bus_reg, up_bus_reg};
               end
               default: begin
                  cfg_rdata_o <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   bbnc_route_dec u_dec (
      .tgt_bus_i (t1_bus_i),
      .special_i (t1_special_i),
      .from_up_i (t1_from_up_i),
      .up_bus_i  (up_bus_reg),
      .dn_bus_i  (dn_bus_reg),
      .hi_bus_i  (hi_bus_reg),
      .route_o   (route_next)
   );

   // Routing is only meaningful once software has set the bus numbers
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         t1_valid_o <= 1'b0;
         t1_route_o <= bbnc_pkg::BBNC_RT_NONE;
      end else begin
         t1_valid_o <= t1_req_i;
         t1_route_o <= t1_req_i ? route_next : bbnc_pkg::BBNC_RT_NONE;
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         up_bus_o <= bbnc_pkg::BBNC_BUS_RST;
         dn_bus_o <= bbnc_pkg::BBNC_BUS_RST;
         hi_bus_o <= bbnc_pkg::BBNC_BUS_RST;
      end else begin
         up_bus_o <= up_bus_reg;
         dn_bus_o <= dn_bus_reg;
         hi_bus_o <= hi_bus_reg;
      end
   end

   property p_hdr_read;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (cfg_req_i && !cfg_wr_i && cfg_addr_i == 8'h0c) |=> (cfg_rdata_o == 32'h0001_0000);
   endproperty
   a_hdr_read: assert property (p_hdr_read) else $error("header dword wrong");

   property p_rsvd_zero;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      cfg_rdata_o[31:24] == 8'h00;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved byte not zero");

   property p_up_write;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr_bus && !cfg_be_n_i[0]) |=> ##1 (up_bus_o == $past(cfg_wdata_i[7:0], 2));
   endproperty
   a_up_write: assert property (p_up_write) else $error("upstream bus not written");

   property p_dn_hold;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr_bus && cfg_be_n_i[1]) |=> (dn_bus_reg == $past(dn_bus_reg));
   endproperty
   a_dn_hold: assert property (p_dn_hold) else $error("disabled byte changed");

   property p_hi_write;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr_bus && !cfg_be_n_i[2]) |=> (hi_bus_reg == $past(cfg_wdata_i[23:16]));
   endproperty
   a_hi_write: assert property (p_hi_write) else $error("highest bus not written");

   property p_type0;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (t1_req_i && t1_from_up_i && !t1_special_i && t1_bus_i == dn_bus_reg)
         |=> (t1_valid_o && t1_route_o == 4'h2);
   endproperty
   a_type0: assert property (p_type0) else $error("type 0 conversion missed");

   property p_pass_dn;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (t1_req_i && t1_from_up_i && t1_bus_i > dn_bus_reg && t1_bus_i <= hi_bus_reg)
         |=> (t1_route_o == 4'h4);
   endproperty
   a_pass_dn: assert property (p_pass_dn) else $error("type 1 pass missed");

   property p_upstream;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (t1_req_i && !t1_from_up_i && !(t1_special_i && t1_bus_i == up_bus_reg))
         |=> (t1_route_o == 4'h4);
   endproperty
   a_upstream: assert property (p_upstream) else $error("upstream pass wrong");

   property p_hdr_const;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (cfg_req_i && cfg_wr_i && cfg_addr_i == 8'h0c) ##1 (cfg_req_i && !cfg_wr_i && cfg_addr_i == 8'h0c)
         |=> (cfg_rdata_o[23:16] == 8'h01);
   endproperty
   a_hdr_const: assert property (p_hdr_const) else $error("header type writable");

   property p_ack_pulse;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      cfg_req_i |=> cfg_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("access not acknowledged");

   property p_ack_idle;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      !cfg_req_i |=> (!cfg_ack_o && cfg_rdata_o == 32'h0000_0000);
   endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("stray acknowledge or data");

   // Hold checks watch the registers, so the lag of the output copies cannot hide a stray write
   property p_up_hold;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr_bus && cfg_be_n_i[0]) |=> (up_bus_reg == $past(up_bus_reg));
   endproperty
   a_up_hold: assert property (p_up_hold) else $error("disabled upstream byte changed");

   property p_hi_hold;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr_bus && cfg_be_n_i[2]) |=> (hi_bus_reg == $past(hi_bus_reg));
   endproperty
   a_hi_hold: assert property (p_hi_hold) else $error("disabled highest byte changed");

   property p_dn_write;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (wr_bus && !cfg_be_n_i[1]) |=> (dn_bus_reg == $past(cfg_wdata_i[15:8]));
   endproperty
   a_dn_write: assert property (p_dn_write) else $error("downstream bus not written");

   property p_hdr_ro;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (cfg_req_i && cfg_wr_i && cfg_addr_i == bbnc_pkg::BBNC_OFS_HDR)
         |=> $stable({hi_bus_reg, dn_bus_reg, up_bus_reg});
   endproperty
   a_hdr_ro: assert property (p_hdr_ro) else $error("header write disturbed bus numbers");

   property p_bus_read;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (cfg_req_i && !cfg_wr_i && cfg_addr_i == bbnc_pkg::BBNC_OFS_BUSNUM)
         |=> (cfg_rdata_o[23:0] == $past({hi_bus_reg, dn_bus_reg, up_bus_reg}));
   endproperty
   a_bus_read: assert property (p_bus_read) else $error("bus number readback wrong");

   property p_unmapped;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (cfg_req_i && !cfg_wr_i && cfg_addr_i != bbnc_pkg::BBNC_OFS_HDR &&
       cfg_addr_i != bbnc_pkg::BBNC_OFS_BUSNUM) |=> (cfg_rdata_o == 32'h0000_0000);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_no_claim;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (t1_req_i && t1_from_up_i && t1_bus_i != dn_bus_reg &&
       !(t1_bus_i > dn_bus_reg && t1_bus_i <= hi_bus_reg)) |=> (t1_route_o == 4'h1);
   endproperty
   a_no_claim: assert property (p_no_claim) else $error("foreign bus claimed");

   property p_spcl_dn;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (t1_req_i && t1_from_up_i && t1_special_i && t1_bus_i == dn_bus_reg)
         |=> (t1_valid_o && t1_route_o == 4'h8);
   endproperty
   a_spcl_dn: assert property (p_spcl_dn) else $error("downstream special cycle missed");

   property p_spcl_up;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      (t1_req_i && !t1_from_up_i && t1_special_i && t1_bus_i == up_bus_reg)
         |=> (t1_valid_o && t1_route_o == 4'h8);
   endproperty
   a_spcl_up: assert property (p_spcl_up) else $error("upstream special cycle missed");

   property p_t1_idle;
      @(posedge sys_clk_i) disable iff (!resetn_i)
      !t1_req_i |=> (!t1_valid_o && t1_route_o == 4'h1);
   endproperty
   a_t1_idle: assert property (p_t1_idle) else $error("stray routing result");

   c_bus_write: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) wr_bus && cfg_be_n_i == 4'h8);
   c_type0: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) t1_valid_o && t1_route_o == 4'h2);
   c_type1: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) t1_valid_o && t1_route_o == 4'h4);
   c_spcl: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) t1_valid_o && t1_route_o == 4'h8);
endmodule : bbnc_top
`default_nettype wire

//--- rtl/bbnc_pkg.sv
package bbnc_pkg;
   localparam logic [7:0] BBNC_OFS_HDR      = 8'h0c;
   localparam logic [7:0] BBNC_OFS_BUSNUM   = 8'h18;
   localparam logic [7:0] BBNC_HDR_TYPE_VAL = 8'h01;
   localparam logic [7:0] BBNC_BUS_RST      = 8'h00;
   localparam logic [7:0] BBNC_SPECIAL_DEV  = 8'hff;
   localparam int         BBNC_UP_LSB       = 0;
   localparam int         BBNC_DN_LSB       = 8;
   localparam int         BBNC_HI_LSB       = 16;
   localparam int         BBNC_HDR_LSB      = 16;
   typedef enum logic [3:0] {
      BBNC_RT_NONE  = 4'h1,
      BBNC_RT_TYPE0 = 4'h2,
      BBNC_RT_TYPE1 = 4'h4,
      BBNC_RT_SPCL  = 4'h8
   } bbnc_route_t;
endpackage : bbnc_pkg

//--- rtl/bbnc_route_dec.sv
`timescale 1ns/10ps
`default_nettype none
module bbnc_route_dec (
   input  wire logic [7:0]   tgt_bus_i,
   input  wire logic         special_i,
   input  wire logic         from_up_i,
   input  wire logic [7:0]   up_bus_i,
   input  wire logic [7:0]   dn_bus_i,
   input  wire logic [7:0]   hi_bus_i,
   output bbnc_pkg::bbnc_route_t route_o
);
   always_comb begin
      route_o = bbnc_pkg::BBNC_RT_NONE;
      if (from_up_i) begin
         if (tgt_bus_i == dn_bus_i) begin
            route_o = special_i ? bbnc_pkg::BBNC_RT_SPCL : bbnc_pkg::BBNC_RT_TYPE0;
         end else if (tgt_bus_i > dn_bus_i && tgt_bus_i <= hi_bus_i) begin
            route_o = bbnc_pkg::BBNC_RT_TYPE1;
         end
      end else begin
         // Special only if also flagged as a special-cycle request
         if (tgt_bus_i == up_bus_i && special_i) begin
            route_o = bbnc_pkg::BBNC_RT_SPCL;
         end else begin
            route_o = bbnc_pkg::BBNC_RT_TYPE1;
         end
      end
   end
endmodule : bbnc_route_dec
`default_nettype wire

//--- testbench/bbnc_host.sv
`timescale 1ns/10ps
`default_nettype none
module bbnc_host (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] rdata_i,
   output logic             req_o,
   output logic             wr_o,
   output logic [7:0]       addr_o,
   output logic [3:0]       be_n_o,
   output logic [31:0]      wdata_o
);
   initial begin
      req_o   = 1'b0;
      wr_o    = 1'b0;
      addr_o  = 8'h00;
      be_n_o  = 4'hf;
      wdata_o = 32'h0;
   end
   // One access per call, held for the taking edge; bench programs bus numbers before the random routing loop, not before the final post-reset request
   task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d, output logic [31:0] q, output logic k);
      @(negedge clk_i);
      req_o   = 1'b1;
      wr_o    = w;
      addr_o  = a;
      be_n_o  = b;
      wdata_o = d;
      @(negedge clk_i);
      req_o   = 1'b0;
      addr_o  = ~a;
      wdata_o = ~d;
      q       = rdata_i;
      k       = ack_i;
   endtask : acc
endmodule : bbnc_host
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk, rstn, req, wr, t1r, t1u, t1s, val, ack;
   logic [7:0]  addr, t1b, upb, dnb, hib;
   logic [3:0]  be_n, rt;
   logic [31:0] wd, rd;
   logic [23:0] busm;
   int checked, miscompares, cyc;
   bbnc_host u_bbnc_host (.clk_i(clk), .ack_i(ack), .rdata_i(rd), .req_o(req), .wr_o(wr),
      .addr_o(addr), .be_n_o(be_n), .wdata_o(wd));
   bbnc_top u_bbnc_top (.sys_clk_i(clk), .resetn_i(rstn), .cfg_req_i(req), .cfg_wr_i(wr),
      .cfg_addr_i(addr), .cfg_be_n_i(be_n), .cfg_wdata_i(wd), .cfg_rdata_o(rd),
      .cfg_ack_o(ack), .t1_req_i(t1r), .t1_from_up_i(t1u), .t1_bus_i(t1b),
      .t1_special_i(t1s), .t1_valid_o(val), .t1_route_o(rt), .up_bus_o(upb),
      .dn_bus_o(dnb), .hi_bus_o(hib));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic end_sim;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
                      input logic [31:0] d, input logic [31:0] e);
      logic [31:0] q;
      logic        k;
      u_bbnc_host.acc(w, a, b, d, q, k);
      chk({31'h0, k}, 32'h1);
      if (w && a == 8'h18)
         for (int i = 0; i < 3; i++)
            if (!b[i]) busm[i*8 +: 8] = d[i*8 +: 8];
      chk(q, e);
   endtask : cfg
   task automatic route(input logic u, input logic [7:0] n, input logic s);
      logic [3:0] e;
      if (u)
         e = (n == busm[15:8]) ? (s ? 4'h8 : 4'h2) :
             (n > busm[15:8] && n <= busm[23:16]) ? 4'h4 : 4'h1;
      else
         e = (s && n == busm[7:0]) ? 4'h8 : 4'h4;
      @(negedge clk);
      t1r = 1'b1;
      t1u = u;
      t1b = n;
      t1s = s;
      @(negedge clk);
      t1r = 1'b0;
      t1b = ~n;
      chk({27'h0, val, rt}, {27'h0, 1'b1, e});
      chk({8'h0, hib, dnb, upb}, {8'h0, busm});
   endtask : route
   initial begin
      rstn = 1'b0;
      t1r  = 1'b0;
      t1u  = 1'b0;
      t1b  = 8'h00;
      t1s  = 1'b0;
      busm = 24'h0;
      void'($urandom(32'h3010));
      repeat (8) @(posedge clk);
      @(negedge clk) rstn = 1'b1;
      cfg(0, 8'h18, 4'h0, 32'h0, 32'h0);
      cfg(0, 8'h0c, 4'h0, 32'h0, 32'h0001_0000);
      cfg(1, 8'h0c, 4'h0, 32'hffff_ffff, 32'h0);
      cfg(0, 8'h0c, 4'h0, 32'h0, 32'h0001_0000);
      cfg(0, 8'h20, 4'h0, 32'h0, 32'h0);
      for (int i = 0; i < 12; i++) begin
         cfg(1, 8'h18, 4'($urandom), $urandom, 32'h0);
         cfg(0, 8'h18, 4'h0, 32'h0, {8'h0, busm});
      end
      cfg(1, 8'h18, 4'h8, 32'hff30_2010, 32'h0);
      for (int i = 0; i < 128; i++)
         route(1'($urandom), (i % 4 == 0) ? busm[7:0] : (i % 4 == 1) ? busm[15:8] :
               8'(8'h0e + $urandom % 40), 1'($urandom));
      @(negedge clk) rstn = 1'b0;
      busm = 24'h0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      cfg(0, 8'h18, 4'h0, 32'h0, 32'h0);
      route(1'b1, 8'h00, 1'b0);
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
